//--- common/optcfg_consts.svh
`ifndef OPTCFG_CONSTS_SVH
`define OPTCFG_CONSTS_SVH
// ==========================================================
// Register addresses.
`define ADDR_OPTION_BYTE0 8'h00
`define ADDR_OPTION_BYTE1 8'h01
`define ADDR_FILTER_CTRL 8'h02
`define ADDR_STATUS 8'h03
// ==========================================================
// Field positions in option byte 0.
`define OB_WDT_ACTION 7
`define OB_WDT_POWER_ON 6
`define OB_OSC_HI 5
`define OB_OSC_LO 4
`define OB_BROWNOUT_AO 3
`define OB_READ_PROTECT 2
`define OB_WRITE_PROTECT 0
// Field positions in the filter control register.
`define FC_MODE_HI 1
`define FC_MODE_LO 0
`define FC_DELAY_HI 4
`define FC_DELAY_LO 2
// ==========================================================
// Erased values and factory presets.
`define ERASED_BYTE 8'hFF
`define FACTORY_DELAY_SEL 3'h0
`define FILTER_MODE_RESET 2'h0
// ==========================================================
// Reject widths in ns, one per delay code.
`define REJECT_NS_0 8'h05
`define REJECT_NS_1 8'h07
`define REJECT_NS_2 8'h09
`define REJECT_NS_3 8'h0B
`define REJECT_NS_4 8'h0D
`define REJECT_NS_5 8'h11
`define REJECT_NS_6 8'h14
`define REJECT_NS_7 8'h19
`define CLK_PERIOD_NS 8'h04
`endif

//--- common/optcfg_pkg.sv
package optcfg_pkg;
  typedef enum logic [1:0] {
    FILT_NONE = 2'b00,
    FILT_LOW_ON_HIGH = 2'b01,
    FILT_HIGH_ON_LOW = 2'b10,
    FILT_BOTH = 2'b11
  } filter_mode_t;
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_FETCH = 2'b01,
    LD_DONE = 2'b10
  } load_state_t;
endpackage

//--- rtl/clock_noise_filter.sv
`include "optcfg_consts.svh"
module clock_noise_filter
  import optcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n_sync,
  input wire logic clk_raw,
  input optcfg_pkg::filter_mode_t mode,
  input wire logic [2:0] delay_sel,
  output logic clk_filtered
);
  // ==========================================================
  // Input synchroniser and glitch rejection.
  logic [2:0] sync;
  logic [2:0] next_sync;
  logic out_q;
  logic next_out;
  logic [7:0] run;
  logic [7:0] next_run;
  logic [7:0] reject_ns;
  logic [7:0] need;
  logic stable;

  always_comb begin
    case (delay_sel)
      3'h0: reject_ns = `REJECT_NS_0;
      3'h1: reject_ns = `REJECT_NS_1;
      3'h2: reject_ns = `REJECT_NS_2;
      3'h3: reject_ns = `REJECT_NS_3;
      3'h4: reject_ns = `REJECT_NS_4;
      3'h5: reject_ns = `REJECT_NS_5;
      3'h6: reject_ns = `REJECT_NS_6;
      default: reject_ns = `REJECT_NS_7;
    endcase
    need = 8'((reject_ns + `CLK_PERIOD_NS - 8'h01) / `CLK_PERIOD_NS);
  end

  assign stable = (sync[1] == sync[2]);

  always_comb begin
    next_sync = {sync[1:0], clk_raw};
    next_run = run;
    next_out = out_q;
    if (!stable || sync[2] == out_q) begin
      next_run = 8'h00;
    end else begin
      next_run = run + 8'h01;
    end
    if (stable && sync[2] != out_q) begin
      case (mode)
        FILT_NONE: next_out = sync[2];
        FILT_LOW_ON_HIGH: next_out = (sync[2] || (run + 8'h01 >= need)) ? sync[2] : out_q;
        FILT_HIGH_ON_LOW: next_out = (!sync[2] || (run + 8'h01 >= need)) ? sync[2] : out_q;
        FILT_BOTH: next_out = (run + 8'h01 >= need) ? sync[2] : out_q;
        default: next_out = sync[2];
      endcase
      if (next_out != out_q) begin
        next_run = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      sync <= 3'h0;
      run <= 8'h00;
      out_q <= 1'b0;
    end else begin
      sync <= next_sync;
      run <= next_run;
      out_q <= next_out;
    end
  end

  assign clk_filtered = out_q;
endmodule

//--- rtl/option_byte_clock_filter_cfg.sv
`include "optcfg_consts.svh"
// How it works
// - Addresses 0 and 1 hold option bytes.
// - Option byte 0 survives every reset.
// - Mode field picks none, low, high, both.
// - Delay code sets rejected pulse width.
// - Delay code arrives factory preset, no calibration.
module option_byte_clock_filter_cfg
  import optcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic clk_raw,
  output logic clk_filtered,
  output logic watchdog_timeout_action_sel,
  output logic watchdog_power_on_enable,
  output logic [1:0] oscillator_drive_select,
  output logic brownout_always_on,
  output logic flash_read_protect,
  output logic flash_write_protect,
  output logic cpu_run_enable
);
  // ==========================================================
  // Reset release.
  logic [1:0] rst_pipe;
  logic rst_n_sync;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_pipe[1];

  // ==========================================================
  // Option storage, never touched by reset.
  logic [7:0] option_mem [0:1] = '{`ERASED_BYTE, `ERASED_BYTE};
  logic [7:0] next_option_mem [0:1];
  logic [7:0] opt_byte1;

  always_comb begin
    next_option_mem = option_mem;
    if (wr && addr == `ADDR_OPTION_BYTE0) begin
      next_option_mem[0] = wdata;
    end
    if (wr && addr == `ADDR_OPTION_BYTE1) begin
      next_option_mem[1] = wdata;
    end
  end

  // Storage has no reset branch, so a reset never alters it.
  always_ff @(posedge clk) begin
    option_mem <= next_option_mem;
  end
  assign opt_byte1 = option_mem[1];

  // ==========================================================
  // Filter control.
  filter_mode_t filt_mode;
  filter_mode_t next_filt_mode;
  logic [2:0] delay_sel;

  assign delay_sel = `FACTORY_DELAY_SEL;

  always_comb begin
    next_filt_mode = filt_mode;
    if (wr && addr == `ADDR_FILTER_CTRL) begin
      next_filt_mode = filter_mode_t'(wdata[`FC_MODE_HI:`FC_MODE_LO]);
    end
  end

  // ==========================================================
  // Load sequence after reset.
  load_state_t state;
  load_state_t next_state;
  logic [7:0] shadow;
  logic [7:0] next_shadow;

  always_comb begin
    next_state = state;
    next_shadow = shadow;
    case (state)
      LD_IDLE: next_state = LD_FETCH;
      LD_FETCH: begin
        next_shadow = option_mem[0];
        next_state = LD_DONE;
      end
      LD_DONE: next_state = LD_DONE;
      default: next_state = LD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state <= LD_IDLE;
      shadow <= `ERASED_BYTE;
      filt_mode <= filter_mode_t'(`FILTER_MODE_RESET);
    end else begin
      state <= next_state;
      shadow <= next_shadow;
      filt_mode <= next_filt_mode;
    end
  end

  assign cpu_run_enable = (state == LD_DONE);
  assign watchdog_timeout_action_sel = shadow[`OB_WDT_ACTION];
  assign watchdog_power_on_enable = shadow[`OB_WDT_POWER_ON];
  assign oscillator_drive_select = shadow[`OB_OSC_HI:`OB_OSC_LO];
  assign brownout_always_on = shadow[`OB_BROWNOUT_AO];
  assign flash_read_protect = shadow[`OB_READ_PROTECT];
  assign flash_write_protect = shadow[`OB_WRITE_PROTECT];

  // ==========================================================
  // Register read port.
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        `ADDR_OPTION_BYTE0: next_rdata = option_mem[0];
        `ADDR_OPTION_BYTE1: next_rdata = opt_byte1;
        `ADDR_FILTER_CTRL: begin
          next_rdata[`FC_MODE_HI:`FC_MODE_LO] = filt_mode;
          next_rdata[`FC_DELAY_HI:`FC_DELAY_LO] = delay_sel;
        end
        `ADDR_STATUS: next_rdata = {7'h00, cpu_run_enable};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Clock filter.
  clock_noise_filter u_filter (
    .clk(clk),
    .rst_n_sync(rst_n_sync),
    .clk_raw(clk_raw),
    .mode(filt_mode),
    .delay_sel(delay_sel),
    .clk_filtered(clk_filtered)
  );
endmodule

//--- tb/optcfg_assertions.sv
// ==========================================================
// Checker on the ports of the configuration block.
module optcfg_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic cpu_run_enable,
  input wire logic watchdog_timeout_action_sel,
  input wire logic [1:0] oscillator_drive_select,
  input wire logic flash_write_protect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_load;
    !cpu_run_enable ##[1:5] cpu_run_enable;
  endsequence
  a_load_after_reset: assert property ($rose(rst_b) |-> s_load)
    else $error("run enable not raised after reset");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_delay_preset: assert property ($past(rd) && $past(addr) == 8'h02 |-> rdata[4:2] == 3'h0)
    else $error("delay code not factory value");
  a_unmapped_zero: assert property ($past(rd) && $past(addr) > 8'h03 |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_run: assert property ($past(rd) && $past(addr) == 8'h03 |->
    rdata == {7'h00, $past(cpu_run_enable)})
    else $error("status read wrong");
  a_fields_hold: assert property (cpu_run_enable && $past(cpu_run_enable) |->
    $stable({watchdog_timeout_action_sel, oscillator_drive_select, flash_write_protect}))
    else $error("option fields changed without reset");
endmodule
bind option_byte_clock_filter_cfg optcfg_checker chk (.*);

//--- tb/option_byte_clock_filter_cfg_tb.sv
module option_byte_clock_filter_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, clk_raw = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [1:0] oscillator_drive_select;
  logic watchdog_timeout_action_sel, watchdog_power_on_enable, brownout_always_on;
  logic flash_read_protect, flash_write_protect, cpu_run_enable, clk_filtered;
  int n_errors = 0, n_tests = 0, cyc = 0;
  wire [7:0] outs = {watchdog_timeout_action_sel, watchdog_power_on_enable,
    oscillator_drive_select, brownout_always_on, flash_read_protect, flash_write_protect,
    cpu_run_enable};
  option_byte_clock_filter_cfg DUT (.*);
  always #2 clk = ~clk;
  // ==========================================================
  // Shared tasks.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
    @(posedge clk);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(outs, 8'hFE);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic edge_lat(input logic lvl, output int n);
    clk_raw <= lvl;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (clk_filtered !== lvl && n < 30);
    @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_erased();
    check(outs, 8'hFF);
    rd_chk(8'h00, 8'hFF);
    rd_chk(8'h01, 8'hFF);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h01);
    wr_reg(8'h40, 8'hAA);
    rd_chk(8'h40, 8'h00);
    $display("t_erased done");
  endtask
  task automatic t_persist();
    wr_reg(8'h00, 8'h5A);
    wr_reg(8'h01, 8'hC3);
    rd_chk(8'h00, 8'h5A);
    rd_chk(8'h01, 8'hC3);
    check(outs, 8'hFF);
    do_reset();
    rd_chk(8'h00, 8'h5A);
    rd_chk(8'h01, 8'hC3);
    check(outs, 8'h59);
    $display("t_persist done");
  endtask
  task automatic t_filter();
    int r, f;
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h02, 8'(m));
      rd_chk(8'h02, 8'(m));
      edge_lat(1'b0, f);
      edge_lat(1'b1, r);
      edge_lat(1'b0, f);
      check({5'h00, r < 30 && f < 30, f > r, r > f}, {5'h00, 1'b1, m == 1, m == 2});
    end
    $display("t_filter done");
  endtask
  task automatic t_glitch();
    logic seen;
    for (int w = 1; w < 5; w += 3) begin
      wr_reg(8'h02, 8'h03);
      seen = 1'b0;
      clk_raw <= 1'b1;
      repeat (w) @(posedge clk);
      clk_raw <= 1'b0;
      repeat (8) begin
        @(posedge clk);
        #1 seen = seen | clk_filtered;
      end
      @(posedge clk);
      check({7'h00, seen}, {7'h00, w > 1});
    end
    $display("t_glitch done");
  endtask
  initial begin
    do_reset();
    t_erased();
    t_persist();
    t_filter();
    t_glitch();
    wrap_up();
  end
endmodule
